// ---- verilog/host_link_watchdog.v ----
// host link watchdog: arms on first host write, bites on a missed refresh
//
// Behaviour
// - after reset stay dormant: no counting, no bite until first host access
// - first host write arms the watchdog; then write intervals are monitored
// - armed watchdog bites unless refreshed; host must refresh often enough
// - each host write reloads timer; gap beyond timeout causes a bite
// - timeout kept in nanoseconds, resets to 5 ms, host may read and rewrite
// - on bite every pin detaches and becomes pulled-up high-impedance input
// - on bite all host communication stops until the flag is cleared
// - bite leaves other function modules running; only pin routing changes
// - bite flag reads true after a bite, false otherwise
// - host writing false to the flag resumes communication and load-time pins
`timescale 1ns/100ps
`default_nettype none
`include "host_link_watchdog_defs.vh"

module host_link_watchdog (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // host side
    input wire host_update_write,
    input wire expiry_wr,
    input wire [31:0] expiry_wdata,
    output wire [31:0] expiry_interval_ns,
    input wire bite_flag_wr,
    input wire bite_flag_wdata,
    output wire bite_flag,
    output wire host_comm_enable,
    // function module pin requests
    input wire [`WD_PIN_COUNT-1:0] func_out,
    input wire [`WD_PIN_COUNT-1:0] func_oe_n,
    // io pins
    output wire [`WD_PIN_COUNT-1:0] pin_out,
    output wire [`WD_PIN_COUNT-1:0] pin_oe_n,
    output wire [`WD_PIN_COUNT-1:0] pin_pullup
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [31:0] expiry_q;
    reg [31:0] count_q;
    reg [31:0] count_d;
    wire [31:0] reload_cycles;
    wire write_ok;

    // round down, at least one cycle: a bite never comes later than the programmed gap unless that gap is under 25 ns
    assign reload_cycles = (expiry_q / `WD_CLK_PERIOD_NS == 32'h0) ? 32'h1 :
        expiry_q / `WD_CLK_PERIOD_NS;

    // refresh writes are ignored while bitten, the link is dead then
    assign write_ok = host_update_write && (state_q != `WD_ST_BITTEN);

    // ------------------------------------------------------------
    // timeout register
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            expiry_q <= `WD_EXPIRY_RESET_NS;
        end else if (expiry_wr) begin
            expiry_q <= expiry_wdata;
        end
    end
    assign expiry_interval_ns = expiry_q;

    // ------------------------------------------------------------
    // state machine and down-counter
    // ------------------------------------------------------------
    always @* begin
        state_d = state_q;
        count_d = count_q;
        case (state_q)
            `WD_ST_DORMANT: begin
                count_d = 32'h0;
                if (host_update_write) begin
                    state_d = `WD_ST_ARMED;
                    count_d = reload_cycles;
                end
            end
            `WD_ST_ARMED: begin
                if (write_ok) begin
                    count_d = reload_cycles;
                end else if (count_q <= 32'h1) begin
                    state_d = `WD_ST_BITTEN;
                    count_d = 32'h0;
                end else begin
                    count_d = count_q - 32'h1;
                end
            end
            `WD_ST_BITTEN: begin
                count_d = 32'h0;
                // a cleared flag resumes; the next write rearms the timer
                if (bite_flag_wr && !bite_flag_wdata) begin
                    state_d = `WD_ST_DORMANT;
                end
            end
            default: begin
                state_d = `WD_ST_DORMANT;
                count_d = 32'h0;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= `WD_ST_DORMANT;
            count_q <= 32'h0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bite_flag = (state_q == `WD_ST_BITTEN);
    assign host_comm_enable = (state_q != `WD_ST_BITTEN);

    // function modules never see the bite; only the pin mux does
    genvar i;
    generate
        for (i = 0; i < `WD_PIN_COUNT; i = i + 1) begin : g_pin
            assign pin_out[i] = bite_flag ? 1'b1 : func_out[i];
            assign pin_oe_n[i] = bite_flag ? 1'b1 : func_oe_n[i];
            assign pin_pullup[i] = bite_flag | func_oe_n[i];
        end
    endgenerate

endmodule // host_link_watchdog
`default_nettype wire

// ---- include/host_link_watchdog_defs.vh ----
// constants for the host link watchdog
`ifndef HOST_LINK_WATCHDOG_DEFS_VH
`define HOST_LINK_WATCHDOG_DEFS_VH
`define WD_CLK_PERIOD_NS 32'd25
`define WD_EXPIRY_RESET_NS 32'd5000000
`define WD_PIN_COUNT 32
`define WD_ST_DORMANT 2'd0
`define WD_ST_ARMED 2'd1
`define WD_ST_BITTEN 2'd2
`endif

// ---- testbench/hlw_chk.sv ----
// watchdog port assertions
`timescale 1ns/100ps
`default_nettype none
module hlw_chk (
    input wire logic clk_sys, rst_n, host_update_write, expiry_wr, bite_flag_wr,
    input wire logic bite_flag_wdata, bite_flag, host_comm_enable,
    input wire logic [31:0] expiry_wdata, expiry_interval_ns, func_oe_n,
    input wire logic [31:0] pin_out, pin_oe_n, pin_pullup);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire clr = bite_flag_wr && !bite_flag_wdata;
    property p_pin; bite_flag |-> &{pin_oe_n, pin_pullup, pin_out}; endproperty
    a_pin: assert property (p_pin) else $error("pins held");
    property p_com; host_comm_enable ^ bite_flag; endproperty
    a_com: assert property (p_com) else $error("comm");
    property p_mux; !bite_flag |-> pin_oe_n == func_oe_n; endproperty
    a_mux: assert property (p_mux) else $error("routing");
    property p_clr; bite_flag && clr |=> !bite_flag; endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_hld; bite_flag && !clr |=> bite_flag; endproperty
    a_hld: assert property (p_hld) else $error("flag hold");
    property p_ewr; expiry_wr |=> expiry_interval_ns == $past(expiry_wdata); endproperty
    a_ewr: assert property (p_ewr) else $error("expiry write");
    property p_kep; !expiry_wr |=> $stable(expiry_interval_ns); endproperty
    a_kep: assert property (p_kep) else $error("expiry kept");
    property p_pet; host_update_write && !bite_flag && expiry_interval_ns > 49 |=> !bite_flag;
    endproperty
    a_pet: assert property (p_pet) else $error("refresh");
endmodule // hlw_chk
`default_nettype wire

// ---- testbench/hlw_host.sv ----
// host writer model
`timescale 1ns/100ps
`default_nettype none
module hlw_host (input wire logic clk_sys, run, input wire logic [7:0] gap,
    output logic host_update_write = 1'b0);
    logic [7:0] cnt_q = 8'h00;
    always @(posedge clk_sys) cnt_q <= run && cnt_q < gap ? cnt_q + 8'h01 : 8'h00;
    always @(posedge clk_sys) host_update_write <= run && cnt_q == gap;
endmodule // hlw_host
`default_nettype wire

// ---- testbench/host_link_watchdog_tb.sv ----
// watchdog bench
`timescale 1ns/100ps
`default_nettype none
module host_link_watchdog_tb;
    logic clk_sys = 0, rst_n = 0, run = 0, expiry_wr = 0, bite_flag_wr = 0, bite_flag_wdata = 0;
    logic [7:0] gap = 8'h02;
    logic [31:0] expiry_wdata = 250, func_out = 0, func_oe_n = 0;
    wire host_update_write, bite_flag, host_comm_enable;
    wire [31:0] expiry_interval_ns, pin_out, pin_oe_n, pin_pullup;
    int mismatches = 0, num_checks = 0, m_st = 0, m_cnt = 0, m_n = 5000000 / 25;
    always #12.5 clk_sys = ~clk_sys;
    hlw_host host_u (.*);
    host_link_watchdog dut_u (.*);
    task automatic check(input logic [31:0] s, e, input string n);
        num_checks++;
        if (s !== e) begin mismatches++; $display("ERROR %s exp %h got %h", n, e, s); end
    endtask
    task automatic summarize;
        if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        {func_out, func_oe_n} <= {$urandom, $urandom};
        if (!rst_n) m_st = 0;
        else if (m_st == 2) m_st = bite_flag_wr && !bite_flag_wdata ? 0 : 2;
        else if (host_update_write) m_st = 1;
        else if (m_st == 1 && m_cnt == 1) m_st = 2;
        m_cnt = host_update_write ? m_n : m_cnt - 1;
        if (expiry_wr) m_n = (expiry_wdata / 25 == 0) ? 1 : expiry_wdata / 25;
    end
    always @(negedge clk_sys) if (rst_n) begin
        check({host_comm_enable, bite_flag}, m_st == 2 ? 1 : 2, "flag");
        check(pin_oe_n, m_st == 2 ? '1 : func_oe_n, "oe_n");
        check(pin_out, m_st == 2 ? '1 : func_out, "pin_out");
        check(pin_pullup, m_st == 2 ? '1 : func_oe_n, "pullup");
    end
    initial begin
        void'($urandom(92909));
        repeat (8) @(posedge clk_sys);
        rst_n <= 1;
        repeat (300) @(posedge clk_sys);
        check(expiry_interval_ns, 5000000, "expiry");
        expiry_wr <= 1;
        @(posedge clk_sys) {expiry_wr, gap, run} <= {1'b0, 8'($urandom_range(7, 2)), 1'b1};
        repeat (200) @(posedge clk_sys);
        gap <= 8'h1f;
        repeat (80) @(posedge clk_sys);
        {run, bite_flag_wr, bite_flag_wdata} <= 3'h3;
        @(posedge clk_sys) bite_flag_wdata <= 0;
        @(posedge clk_sys) {bite_flag_wr, expiry_wr, expiry_wdata, gap} <= {2'h1, 32'd49, 8'h02};
        @(posedge clk_sys) {expiry_wr, run} <= 2'h1;
        repeat (20) @(posedge clk_sys);
        summarize;
    end
endmodule // host_link_watchdog_tb
bind host_link_watchdog hlw_chk chk_u (.*);
`default_nettype wire
